// ### ssw_pkg.sv
// Constants and carrier types for the stepper status word block.
// Function
// R1: Mode bit high in configuration mode, starts command.
// R2: No valid configuration: current off, motion refused.
// R3: Config fault set at boot/invalid write, cleared valid.
// R4: Stall detect in config mode sets config fault.
// R5: Healthy flag low while internal fault present.
// R6: Bad command flag cleared only by reset-errors.
// R7: Input fault from estop, limits, jog, homing.
// R8: Position invalid causes; absolute moves rejected.
// R9: Programming and segment ready flags for assembled moves.
// R10: Move done set on finish, cleared by next.
// R11: Move done with bad command on jog range.
// R12: Decel, accel, hold and direction flags follow motion.
// R13: Homed after homing success; stopped when not moving.
// R14: Enable mirrored; current off on fault, zero idle.
// R15: Output one and input levels reported.
// R16: Alive toggle every 500 ms in command mode.
// R17: Limit flag set at limit, cleared on release.
// R18: Bad parameter change on jog or gearing range.
// R19: Rotor lag flag when trailing over one revolution.
// R20: Fault cleared by 0x0400 pair, current stays off.
// R21: Physical link loss sets link lost, input fault; the code sets both only when the link is restored after a loss.
// R22: Overheat warning above 90 degrees.
package ssw_pkg;

    // ========================================================================
    // Register map and command fields
    // ========================================================================
    localparam logic [15:0] SSW_ADDR_CMD_UPPER   = 16'h0400;
    localparam logic [15:0] SSW_ADDR_CMD_LOWER   = 16'h0401;
    localparam logic [15:0] SSW_FAULT_CLEAR_WORD = 16'h0400;
    localparam int          SSW_RESET_ERRORS_BIT = 10;
    localparam int          SSW_DRIVE_ENABLE_BIT = 15;
    localparam int          SSW_CLEAR_FAULT_BIT  = 10;
    localparam logic [15:0] SSW_STATUS_RESET     = 16'h0000;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int SSW_CLK_HZ        = 40_000_000;
    localparam int SSW_ALIVE_MS      = 500;
    localparam int SSW_ALIVE_CYCLES  = (SSW_CLK_HZ / 1000) * SSW_ALIVE_MS;

    // ========================================================================
    // Carrier types
    // ========================================================================
    typedef struct packed {
        logic config_mode;
        logic config_valid_written;
        logic config_invalid_written;
        logic config_loaded_boot;
        logic stall_detect_enabled;
        logic internal_fault;
        logic invalid_command;
        logic range_error_jog_reg;
        logic estop;
        logic limit_in_move;
        logic jog_into_limit;
        logic opposite_limit_homing;
        logic position_preset;
        logic homing_done;
        logic immediate_stop;
        logic stall_detected;
        logic move_finished_ok;
        logic move_command;
        logic programming_ready;
        logic segment_ready;
        logic decelerating;
        logic accelerating;
        logic in_hold;
        logic moving_ccw;
        logic moving_cw;
        logic motor_idle;
        logic idle_reduction_zero;
        logic overtemp_fault;
        logic short_fault;
        logic limit_input_active;
        logic bad_jog_parameter;
        logic bad_gearing_ratio;
        logic rotor_lag;
        logic link_physical_lost;
        logic link_restored;
        logic host_program_state;
        logic overheat;
        logic output_one_level;
        logic input_three_level;
        logic input_two_level;
        logic input_one_level;
    } ssw_event_type;

    typedef struct packed {
        logic [15:0] motion_status_primary;
        logic [15:0] drive_status_secondary;
        logic        motor_current_on;
        logic        motion_permitted;
        logic        absolute_move_permitted;
    } ssw_report_type;

endpackage : ssw_pkg

// ### ssw_status.sv
// Status word builder and command word decoder for the stepper indexer.
`timescale 1ns/100ps
module ssw_status
    import ssw_pkg::*;
#(
    parameter int ALIVE_CYCLES = SSW_ALIVE_CYCLES
)
(
    // Clock, reset and enable
    input  wire logic           clk,
    input  wire logic           rst_b,
    input  wire logic           clk_en,
    // Command word writes
    input  wire logic           cmd_write,
    input  wire logic [15:0]    cmd_addr,
    input  wire logic [15:0]    cmd_data,
    // Events from motion core and pins
    input  wire ssw_event_type  events,
    // Status words and power control
    output ssw_report_type      report
);

    // ========================================================================
    // Reset release
    // ========================================================================
    logic [1:0] rst_sync;
    logic       rst_int_b;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_int_b = rst_sync[1];

    // ========================================================================
    // Pin synchronisers for the level inputs
    // ========================================================================
    // Pins are the limit input and the last four fields of the event bundle: output and inputs.
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;

    always_ff @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            pin_meta <= 5'h00;
            pin_sync <= 5'h00;
        end
        else if (clk_en)
        begin
            pin_meta <= {events.limit_input_active, events.output_one_level,
                         events.input_three_level, events.input_two_level, events.input_one_level};
            pin_sync <= pin_meta;
        end
    end

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic        config_mode;
        logic        config_fault;
        logic        config_valid;
        logic        bad_command;
        logic        input_fault;
        logic        position_invalid;
        logic        move_done;
        logic        homed;
        logic        power_stage_enabled;
        logic        power_stage_fault;
        logic        end_limit_active;
        logic        bad_parameter_change;
        logic        link_lost;
        logic        link_was_lost;
        logic        alive_toggle;
        logic        limit_prev;
        logic [31:0] alive_count;
        ssw_report_type out;
    } ssw_state_type;

    ssw_state_type state;
    ssw_state_type next_state;

    logic        wr_upper;
    logic        wr_lower;
    logic        reset_errors;
    logic        fault_clear;
    logic [15:0] last_upper;

    // The upper word is latched so the pairing of both words can be checked
    // when the lower word completes the block.
    always_ff @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
            last_upper <= 16'h0000;
        else if (clk_en && wr_upper)
            last_upper <= cmd_data;
    end

    always_comb
    begin
        wr_upper     = cmd_write && (cmd_addr == SSW_ADDR_CMD_UPPER);
        wr_lower     = cmd_write && (cmd_addr == SSW_ADDR_CMD_LOWER);
        reset_errors = wr_upper && cmd_data[SSW_RESET_ERRORS_BIT];
        fault_clear  = wr_lower && (last_upper == SSW_FAULT_CLEAR_WORD)
                       && (cmd_data == SSW_FAULT_CLEAR_WORD); // R20
    end

    always_comb
    begin
        next_state = state;

        // Mode and configuration validity.
        next_state.config_mode = events.config_mode; // R1
        if (events.config_valid_written || events.config_loaded_boot)
            next_state.config_valid = 1'b1;
        else if (events.config_invalid_written)
            next_state.config_valid = 1'b0;
        next_state.config_fault = !next_state.config_valid
                                  || (events.config_mode && events.stall_detect_enabled); // R3 R4

        // Error latches: set wins over clear in the same cycle.
        if (reset_errors)
            next_state.bad_command = 1'b0;
        if (events.invalid_command)
            next_state.bad_command = 1'b1; // R6

        if (reset_errors)
            next_state.input_fault = 1'b0;
        if (events.estop || events.limit_in_move || events.jog_into_limit
            || events.opposite_limit_homing || (state.link_was_lost && events.link_restored))
            next_state.input_fault = 1'b1; // R7 R21

        if (events.position_preset || events.homing_done)
            next_state.position_invalid = 1'b0;
        if (events.config_valid_written || events.config_invalid_written || events.link_restored
            || events.immediate_stop || events.estop || events.limit_in_move || events.stall_detected)
            next_state.position_invalid = 1'b1; // R8

        if (events.move_command || events.position_preset || reset_errors)
            next_state.move_done = 1'b0;
        if (events.move_finished_ok || events.range_error_jog_reg)
            next_state.move_done = 1'b1; // R10 R11
        if (events.range_error_jog_reg)
            next_state.bad_command = 1'b1; // R11

        if (events.move_command)
            next_state.homed = 1'b0;
        if (events.homing_done)
            next_state.homed = 1'b1; // R13

        // Command word fields.
        if (wr_lower)
            next_state.power_stage_enabled = cmd_data[SSW_DRIVE_ENABLE_BIT]; // R14
        if (fault_clear)
            next_state.power_stage_fault = 1'b0;
        if (state.power_stage_enabled && (events.overtemp_fault || events.short_fault))
            next_state.power_stage_fault = 1'b1; // R20

        // Limit flag clears on the active-to-inactive edge of the input.
        next_state.limit_prev = pin_sync[4];
        if (reset_errors || (state.limit_prev && !pin_sync[4]))
            next_state.end_limit_active = 1'b0;
        if (events.limit_in_move)
            next_state.end_limit_active = 1'b1; // R17

        if (reset_errors)
            next_state.bad_parameter_change = 1'b0;
        if (events.bad_jog_parameter || events.bad_gearing_ratio)
            next_state.bad_parameter_change = 1'b1; // R18

        if (events.link_physical_lost)
            next_state.link_was_lost = 1'b1;
        if (reset_errors)
            next_state.link_lost = 1'b0;
        if (state.link_was_lost && events.link_restored)
        begin
            next_state.link_lost     = 1'b1; // R21
            next_state.link_was_lost = 1'b0;
        end

        // Heartbeat runs only in command mode.
        if (events.config_mode)
            next_state.alive_count = 32'h0;
        else if (state.alive_count >= 32'(ALIVE_CYCLES - 1))
        begin
            next_state.alive_count  = 32'h0;
            next_state.alive_toggle = !state.alive_toggle; // R16
        end
        else
            next_state.alive_count = state.alive_count + 32'h1;

        // Output assembly.
        next_state.out.motion_status_primary = {
            state.config_mode, !events.internal_fault, state.config_fault, state.bad_command,
            state.input_fault, state.position_invalid, events.segment_ready, events.programming_ready,
            state.move_done, events.decelerating, events.accelerating, state.homed,
            events.motor_idle, events.in_hold, events.moving_ccw, events.moving_cw}; // R5 R9 R12 R13
        next_state.out.drive_status_secondary = {
            state.power_stage_enabled, events.stall_detected, pin_sync[3], 1'b0,
            state.alive_toggle, state.end_limit_active, state.bad_parameter_change, events.rotor_lag,
            state.power_stage_fault, state.link_lost, events.host_program_state, events.overheat,
            1'b0, pin_sync[2:0]}; // R15 R19 R22
        next_state.out.motor_current_on = state.config_valid && state.power_stage_enabled
                                          && !state.power_stage_fault
                                          && !(events.motor_idle && events.idle_reduction_zero); // R2 R14
        next_state.out.motion_permitted        = state.config_valid && !state.config_mode; // R2
        next_state.out.absolute_move_permitted = state.config_valid && !state.position_invalid; // R8
    end

    always_ff @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            state                            <= '0;
            state.position_invalid           <= 1'b1;
            state.config_fault               <= 1'b1;
            state.out.motion_status_primary  <= SSW_STATUS_RESET;
            state.out.drive_status_secondary <= SSW_STATUS_RESET;
        end
        else if (clk_en)
            state <= next_state;
    end

    assign report = state.out;

endmodule : ssw_status

// ### ssw_sva.sv
// Assertion checker for the stepper status word block.
`timescale 1ns/100ps
module ssw_sva
    import ssw_pkg::*;
#(
    parameter int ALIVE_CYCLES = SSW_ALIVE_CYCLES
)
(
    // Clock and control
    input wire logic           clk,
    input wire logic           rst_b,
    input wire logic           clk_en,
    // Command writes and events
    input wire logic           cmd_write,
    input wire logic [15:0]    cmd_addr,
    input wire logic [15:0]    cmd_data,
    input wire ssw_event_type  events,
    // Status words
    input wire ssw_report_type report
);
    // ====================
    // Settling qualifier
    // ====================
    logic [2:0]  run_cnt;
    logic        ok;
    logic        clr;
    logic [15:0] w1;
    logic [15:0] w2;
    assign w1 = report.motion_status_primary;
    assign w2 = report.drive_status_secondary;
    assign ok = run_cnt == 3'h7;
    assign clr = cmd_write && cmd_addr == SSW_ADDR_CMD_UPPER && cmd_data[SSW_RESET_ERRORS_BIT];
    // History is trusted only after a clean enabled run past the reset synchroniser.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            run_cnt <= 3'h0;
        else if (!clk_en)
            run_cnt <= 3'h0;
        else if (!ok)
            run_cnt <= run_cnt + 3'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ====================
    // Properties
    // ====================
    property p_mode;
        ok |-> w1[15] == $past(events.config_mode, 2);
    endproperty
    a_mode: assert property (p_mode) else $error("mode bit wrong");
    property p_healthy;
        ok |-> w1[14] == !$past(events.internal_fault);
    endproperty
    a_healthy: assert property (p_healthy) else $error("healthy bit wrong");
    property p_err_hold;
        ok && $past(w1[12]) && !$past(clr, 2) |-> w1[12];
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("bad command flag dropped");
    property p_jog_range;
        ok && $past(events.range_error_jog_reg, 2) |-> w1[12] && w1[7];
    endproperty
    a_jog_range: assert property (p_jog_range) else $error("range error flags missing");
    property p_input_fault;
        ok && $past(events.estop || events.jog_into_limit || events.opposite_limit_homing, 2) |-> w1[11];
    endproperty
    a_input_fault: assert property (p_input_fault) else $error("input fault missing");
    property p_pos_inv;
        ok && $past(events.immediate_stop || events.stall_detected, 2) |-> w1[10] && !report.absolute_move_permitted;
    endproperty
    a_pos_inv: assert property (p_pos_inv) else $error("position invalid missing");
    property p_current;
        ok && (!w2[15] || w2[7]) |-> !report.motor_current_on;
    endproperty
    a_current: assert property (p_current) else $error("current on while disabled or faulted");
    sequence s_flip;
        ok && !w1[15] && $changed(w2[11]);
    endsequence
    property p_alive;
        s_flip |=> $stable(w2[11])[*7];
    endproperty
    a_alive: assert property (p_alive) else $error("alive toggle too early");
endmodule : ssw_sva

bind ssw_status ssw_sva #(.ALIVE_CYCLES(ALIVE_CYCLES)) u_sva (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .events(events), .report(report));

// ### ssw_host.sv
// Host controller model that writes command words.
`timescale 1ns/100ps
module ssw_host
    import ssw_pkg::*;
(
    // Clock
    input  wire logic  clk,
    // Command bus
    output logic        cmd_write,
    output logic [15:0] cmd_addr,
    output logic [15:0] cmd_data
);
    initial
    begin
        cmd_write = 1'b0;
        cmd_addr  = 16'h0000;
        cmd_data  = 16'hffff;
    end
    // The released bus is scrambled so a stale word never looks valid.
    task automatic put(input logic [15:0] addr, input logic [15:0] data);
        @(negedge clk);
        cmd_write = 1'b1;
        cmd_addr  = addr;
        cmd_data  = data;
        @(negedge clk);
        cmd_write = 1'b0;
        cmd_addr  = ~addr;
        cmd_data  = ~data;
    endtask : put
    // Upper word always goes first so the pair is taken as one command.
    task automatic command(input logic [15:0] upper, input logic [15:0] lower);
        put(SSW_ADDR_CMD_UPPER, upper);
        put(SSW_ADDR_CMD_LOWER, lower);
    endtask : command
endmodule : ssw_host

// ### testbench.sv
// Self-checking testbench for the stepper status word block.
`timescale 1ns/100ps
module testbench
    import ssw_pkg::*;
;
    localparam int  ALIVE = 8;
    logic           clk = 1'b0;
    logic           rst_b = 1'b0;
    logic           run = 1'b1;
    logic           cmd_write;
    logic [15:0]    cmd_addr;
    logic [15:0]    cmd_data;
    ssw_event_type  ev = '0;
    ssw_report_type rep;
    int             failures = 0;
    int             n_compared = 0;
    int             flips;
    always #12.5 clk = ~clk;
    ssw_host host (.clk(clk), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data));
    ssw_status #(.ALIVE_CYCLES(ALIVE)) uut (.clk(clk), .rst_b(rst_b), .clk_en(run), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .events(ev), .report(rep));
    // ====================
    // Helpers
    // ====================
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic sw(input string what, input bit two, input logic [15:0] m, input logic [15:0] e);
        chk(what, e, (two ? rep.drive_status_secondary : rep.motion_status_primary) & m);
    endtask : sw
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic pulse(input ssw_event_type p);
        ev = ev | p;
        cyc(1);
        ev = ev & ~p;
        cyc(3);
    endtask : pulse
    task automatic count_flips;
        logic prev;
        flips = 0;
        prev = rep.drive_status_secondary[11];
        repeat (4 * ALIVE)
        begin
            cyc(1);
            flips += int'(rep.drive_status_secondary[11] !== prev);
            prev = rep.drive_status_secondary[11];
        end
    endtask : count_flips
    // ====================
    // Scenarios
    // ====================
    task automatic t_boot;
        sw("boot word", 0, 16'he400, 16'h6400);
        chk("boot power", 16'h0000, {14'h0, rep.motor_current_on, rep.motion_permitted});
        pulse('{config_valid_written: 1'b1, default: 1'b0});
        sw("config fault", 0, 16'h2000, 16'h0000);
        chk("motion ok", 16'h0001, {15'h0, rep.motion_permitted});
        $display("t_boot done");
    endtask : t_boot
    task automatic t_errors;
        pulse('{invalid_command: 1'b1, estop: 1'b1, move_finished_ok: 1'b1, default: 1'b0});
        sw("errors set", 0, 16'h1c80, 16'h1c80);
        host.command(16'h0000, 16'h0000);
        cyc(3);
        sw("errors stay", 0, 16'h1800, 16'h1800);
        host.command(16'h0400, 16'h0000);
        cyc(3);
        sw("errors cleared", 0, 16'h1880, 16'h0000);
        pulse('{range_error_jog_reg: 1'b1, default: 1'b0});
        sw("range error", 0, 16'h1080, 16'h1080);
        pulse('{move_command: 1'b1, default: 1'b0});
        pulse('{invalid_command: 1'b1, default: 1'b0});
        sw("move cleared", 0, 16'h1080, 16'h1000);
        host.command(16'h0400, 16'h0000);
        $display("t_errors done");
    endtask : t_errors
    task automatic t_fault;
        host.command(16'h0000, 16'h8000);
        cyc(3);
        sw("enable", 1, 16'h8080, 16'h8000);
        chk("current on", 16'h0001, {15'h0, rep.motor_current_on});
        pulse('{overtemp_fault: 1'b1, default: 1'b0});
        sw("fault", 1, 16'h8080, 16'h8080);
        chk("current fault", 16'h0000, {15'h0, rep.motor_current_on});
        host.command(SSW_FAULT_CLEAR_WORD, SSW_FAULT_CLEAR_WORD);
        cyc(3);
        sw("fault cleared", 1, 16'h8080, 16'h0000);
        chk("current off", 16'h0000, {15'h0, rep.motor_current_on});
        $display("t_fault done");
    endtask : t_fault
    task automatic t_alive;
        count_flips;
        chk("alive flips", 16'h0004, 16'(flips));
        ev.config_mode = 1'b1;
        ev.stall_detect_enabled = 1'b1;
        cyc(3);
        sw("config mode", 0, 16'ha000, 16'ha000);
        count_flips;
        chk("alive frozen", 16'h0000, 16'(flips));
        ev.config_mode = 1'b0;
        ev.stall_detect_enabled = 1'b0;
        $display("t_alive done");
    endtask : t_alive
    task automatic t_pins;
        ev.output_one_level = 1'b1;
        ev.input_three_level = 1'b1;
        ev.input_one_level = 1'b1;
        ev.overheat = 1'b1;
        cyc(6);
        sw("pins", 1, 16'h2017, 16'h2015);
        pulse('{link_physical_lost: 1'b1, default: 1'b0});
        pulse('{link_restored: 1'b1, default: 1'b0});
        sw("link lost", 1, 16'h0040, 16'h0040);
        sw("link input", 0, 16'h0800, 16'h0800);
        $display("t_pins done");
    endtask : t_pins
    task automatic t_flags;
        ssw_event_type a;
        ssw_event_type b;
        a = '{internal_fault: 1'b1, segment_ready: 1'b1, decelerating: 1'b1, in_hold: 1'b1, moving_ccw: 1'b1,
              stall_detected: 1'b1, host_program_state: 1'b1, default: 1'b0};
        b = '{programming_ready: 1'b1, accelerating: 1'b1, motor_idle: 1'b1, moving_cw: 1'b1, rotor_lag: 1'b1,
              default: 1'b0};
        ev = ev | a;
        cyc(3);
        sw("levels a", 0, 16'h436f, 16'h0246);
        sw("drive a", 1, 16'h4120, 16'h4020);
        chk("abs refused", 16'h0000, {15'h0, rep.absolute_move_permitted});
        ev = (ev & ~a) | b;
        cyc(3);
        sw("levels b", 0, 16'h436f, 16'h4129);
        sw("drive b", 1, 16'h4120, 16'h0100);
        ev = ev & ~b;
        pulse('{homing_done: 1'b1, default: 1'b0});
        sw("homed", 0, 16'h0410, 16'h0010);
        chk("abs allowed", 16'h0001, {15'h0, rep.absolute_move_permitted});
        pulse('{move_command: 1'b1, default: 1'b0});
        sw("homed cleared", 0, 16'h0010, 16'h0000);
        $display("t_flags done");
    endtask : t_flags
    task automatic t_limits;
        ev.limit_input_active = 1'b1;
        cyc(6);
        pulse('{limit_in_move: 1'b1, default: 1'b0});
        sw("limit set", 1, 16'h0400, 16'h0400);
        sw("limit input", 0, 16'h0c00, 16'h0c00);
        ev.limit_input_active = 1'b0;
        cyc(6);
        sw("limit released", 1, 16'h0400, 16'h0000);
        pulse('{bad_jog_parameter: 1'b1, default: 1'b0});
        sw("bad param", 1, 16'h0200, 16'h0200);
        host.command(16'h0400, 16'h0000);
        cyc(3);
        sw("param cleared", 1, 16'h0200, 16'h0000);
        $display("t_limits done");
    endtask : t_limits
    task automatic t_freeze;
        run = 1'b0;
        pulse('{invalid_command: 1'b1, default: 1'b0});
        run = 1'b1;
        cyc(3);
        sw("frozen", 0, 16'h1000, 16'h0000);
        $display("t_freeze done");
    endtask : t_freeze
    task automatic t_reset;
        rst_b = 1'b0;
        cyc(2);
        sw("in reset w1", 0, 16'hffff, 16'h0000);
        sw("in reset w2", 1, 16'hffff, 16'h0000);
        rst_b = 1'b1;
        cyc(4);
        sw("reboot word", 0, 16'he400, 16'h6400);
        chk("reboot power", 16'h0000, {14'h0, rep.motor_current_on, rep.motion_permitted});
        $display("t_reset done");
    endtask : t_reset
    task automatic test_done;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    initial
    begin
        cyc(16);
        rst_b = 1'b1;
        cyc(4);
        t_boot;
        t_errors;
        t_fault;
        t_alive;
        t_pins;
        t_flags;
        t_limits;
        t_freeze;
        t_reset;
        test_done;
    end
endmodule : testbench
